// *** iwdt_pkg.sv ***
/*
 Package for the indexed watchdog timer: port numbers, register indexes,
 field positions, reset values and timing constants.
 Assumes a single 40 MHz system clock.
*/
`default_nettype none
package iwdt_pkg;
   // ****************************************
   // Bus ports and register indexes
   // ****************************************
   localparam logic [7:0] IWDT_PORT_INDEX   = 8'h22;
   localparam logic [7:0] IWDT_PORT_DATA    = 8'h23;
   localparam logic [7:0] IWDT_IDX_LOCK     = 8'h13;
   localparam logic [7:0] IWDT_IDX_CTRL     = 8'h37;
   localparam logic [7:0] IWDT_IDX_ACTION   = 8'h38;
   localparam logic [7:0] IWDT_IDX_CNT_LO   = 8'h39;
   localparam logic [7:0] IWDT_IDX_CNT_MID  = 8'h3a;
   localparam logic [7:0] IWDT_IDX_CNT_HI   = 8'h3b;
   localparam logic [7:0] IWDT_IDX_STATUS   = 8'h3c;
   localparam logic [7:0] IWDT_KEY_UNLOCK   = 8'hc5;
   localparam logic [7:0] IWDT_KEY_LOCK     = 8'h00;
   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int         IWDT_CTRL_EN_BIT  = 6;
   localparam int         IWDT_CTRL_RDM_BIT = 7;
   localparam int         IWDT_STAT_TO_BIT  = 7;
   localparam int         IWDT_STAT_RST_BIT = 5;
   localparam logic [7:0] IWDT_CTRL_RESET   = 8'h00;
   localparam logic [7:0] IWDT_ACTION_RESET = 8'h00;
   localparam logic [3:0] IWDT_ACT_NMI      = 4'hc;
   localparam logic [3:0] IWDT_ACT_SYSRST   = 4'hd;
   localparam int         IWDT_IRQ_CODES    = 11;
   // ****************************************
   // Timing
   // ****************************************
   localparam real        IWDT_CLK_NS       = 25.0;
   localparam real        IWDT_TICK_US      = 30.5;
   localparam int         IWDT_TICK_CYCLES  = int'($floor(IWDT_TICK_US * 1000.0 / IWDT_CLK_NS));
   localparam int         IWDT_PULSE_CYCLES = 1;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } iwdt_io_type;

   typedef struct packed {
      logic        nmi;
      logic        sys_rst;
      logic [10:0] irq;
   } iwdt_action_type;
endpackage : iwdt_pkg
`default_nettype wire

// *** iwdt_top.sv ***
/*
 Indexed watchdog timer: index/data I/O port pair, unlock key, 24-bit
 timeout in ticks of about 30.5 us, selectable expiry action.
 Assumes the I/O strobes are synchronous single-cycle pulses on i_sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module iwdt_top
   import iwdt_pkg::*;
#(
   parameter int TICK_CYCLES = IWDT_TICK_CYCLES
)(
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst_n,
   input  wire logic                  i_clk_en,
   input  wire iwdt_pkg::iwdt_io_type i_io,
   output logic [7:0]                 o_rdata,
   output logic                       o_rvalid,
   output iwdt_pkg::iwdt_action_type  o_action
);
   import iwdt_pkg::*;

   if (TICK_CYCLES < 1 || TICK_CYCLES > 65535)
   begin : g_bad_tick
      $error("TICK_CYCLES out of range");
   end

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0]      index;
      logic            unlocked;
      logic [7:0]      ctrl;
      logic [7:0]      act_sel;
      logic [23:0]     timeout;
      logic [23:0]     snap;
      logic [23:0]     live;
      logic [15:0]     prescale;
      logic            expired;
      logic            fired;
      logic [7:0]      rdata;
      logic            rvalid;
      iwdt_action_type action;
   } iwdt_state_type;

   iwdt_state_type st;
   iwdt_state_type next_st;

   logic wr_data;
   logic rd_data;
   logic restart;
   logic tick;
   logic hit;

   function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [1:0] sel,
                                            input logic [7:0] b);
      logic [23:0] r;
      r = v;
      r[sel*8 +: 8] = b;
      return r;
   endfunction : put_byte

   always_comb
   begin
      next_st = st;
      wr_data = i_io.wr && i_io.addr == IWDT_PORT_DATA;
      rd_data = i_io.rd && i_io.addr == IWDT_PORT_DATA;
      restart = wr_data && st.unlocked && st.index == IWDT_IDX_STATUS
                && i_io.wdata[IWDT_STAT_RST_BIT];
      tick    = st.prescale == 16'(TICK_CYCLES - 1);
      hit     = st.ctrl[IWDT_CTRL_EN_BIT] && tick && !st.fired
                && st.live + 24'h1 >= st.timeout;
      next_st.rvalid = 1'b0;
      next_st.action = '0;

      if (i_io.wr && i_io.addr == IWDT_PORT_INDEX)
         next_st.index = i_io.wdata;
      // The lock register itself is always writable, otherwise it could never open.
      if (wr_data && st.index == IWDT_IDX_LOCK)
      begin
         if (i_io.wdata == IWDT_KEY_UNLOCK)
            next_st.unlocked = 1'b1;
         else if (i_io.wdata == IWDT_KEY_LOCK)
            next_st.unlocked = 1'b0;
      end
      if (wr_data && st.unlocked)
      begin
         case (st.index)
            IWDT_IDX_CTRL:    next_st.ctrl = i_io.wdata;
            IWDT_IDX_ACTION:  next_st.act_sel = i_io.wdata;
            IWDT_IDX_CNT_LO:  next_st.timeout = put_byte(st.timeout, 2'd0, i_io.wdata);
            IWDT_IDX_CNT_MID: next_st.timeout = put_byte(st.timeout, 2'd1, i_io.wdata);
            IWDT_IDX_CNT_HI:  next_st.timeout = put_byte(st.timeout, 2'd2, i_io.wdata);
            default:          next_st.index = st.index;
         endcase
         // Snapshot is taken on the write that raises the read-mode bit.
         if (st.index == IWDT_IDX_CTRL && i_io.wdata[IWDT_CTRL_RDM_BIT]
             && !st.ctrl[IWDT_CTRL_RDM_BIT])
            next_st.snap = st.live;
      end

      if (rd_data)
      begin
         next_st.rvalid = 1'b1;
         case (st.index)
            IWDT_IDX_LOCK:    next_st.rdata = {7'h00, st.unlocked};
            IWDT_IDX_CTRL:    next_st.rdata = st.ctrl;
            IWDT_IDX_ACTION:  next_st.rdata = st.act_sel;
            IWDT_IDX_CNT_LO:  next_st.rdata = st.ctrl[IWDT_CTRL_RDM_BIT] ? st.snap[7:0]
                                                                          : st.timeout[7:0];
            IWDT_IDX_CNT_MID: next_st.rdata = st.ctrl[IWDT_CTRL_RDM_BIT] ? st.snap[15:8]
                                                                          : st.timeout[15:8];
            IWDT_IDX_CNT_HI:  next_st.rdata = st.ctrl[IWDT_CTRL_RDM_BIT] ? st.snap[23:16]
                                                                          : st.timeout[23:16];
            IWDT_IDX_STATUS:  next_st.rdata = {st.expired, 7'h00};
            default:          next_st.rdata = 8'h00;
         endcase
      end

      // Counting: the prescaler runs only while enabled so a disabled timer holds still.
      if (!st.ctrl[IWDT_CTRL_EN_BIT] || restart)
         next_st.prescale = '0;
      else
         next_st.prescale = tick ? 16'h0 : st.prescale + 16'h1;
      if (restart)
      begin
         next_st.live  = '0;
         next_st.fired = 1'b0;
      end
      else if (st.ctrl[IWDT_CTRL_EN_BIT] && tick && !st.fired)
         next_st.live = st.live + 24'h1;

      if (hit && !restart)
      begin
         next_st.fired   = 1'b1;
         next_st.expired = 1'b1;
         case (st.act_sel[7:4])
            IWDT_ACT_NMI:    next_st.action.nmi = 1'b1;
            IWDT_ACT_SYSRST: next_st.action.sys_rst = 1'b1;
            4'h0, 4'he, 4'hf: next_st.action = '0;
            default:         next_st.action.irq[st.act_sel[7:4] - 4'h1] = 1'b1;
         endcase
      end
      if (!i_clk_en)
         next_st = st;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st          <= '0;
         st.ctrl     <= IWDT_CTRL_RESET;
         st.act_sel  <= IWDT_ACTION_RESET;
         st.timeout  <= 24'hffffff;
      end
      else
         st <= next_st;
   end

   assign o_rdata  = st.rdata;
   assign o_rvalid = st.rvalid;
   assign o_action = st.action;

   // ****************************************
   // Assertions
   // ****************************************
   property p_unlock;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && wr_data && st.index == IWDT_IDX_LOCK && i_io.wdata == IWDT_KEY_UNLOCK
      |=> st.unlocked;
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock key ignored");

   property p_locked_ctrl;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      !st.unlocked |=> $stable(st.ctrl);
   endproperty
   a_locked_ctrl: assert property (p_locked_ctrl) else $error("ctrl changed locked");

   property p_read_prog;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && rd_data && st.index == IWDT_IDX_CNT_HI && !st.ctrl[IWDT_CTRL_RDM_BIT]
      |=> o_rvalid && o_rdata == $past(st.timeout[23:16]);
   endproperty
   a_read_prog: assert property (p_read_prog) else $error("bad count read");

   property p_status_read;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && rd_data && st.index == IWDT_IDX_STATUS
      |=> o_rdata[7] == $past(st.expired) && o_rdata[6:0] == 7'h00;
   endproperty
   a_status_read: assert property (p_status_read) else $error("bad status");

   property p_sticky;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      st.expired |=> st.expired;
   endproperty
   a_sticky: assert property (p_sticky) else $error("timeout flag lost");

   property p_restart;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && restart |=> st.live == 24'h0 && !st.fired;
   endproperty
   a_restart: assert property (p_restart) else $error("restart failed");

   property p_nmi;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && hit && !restart && st.act_sel[7:4] == IWDT_ACT_NMI
      |=> o_action.nmi && st.expired ##1 !o_action.nmi;
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi action wrong");

   property p_disabled;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      !st.ctrl[IWDT_CTRL_EN_BIT] && !restart |=> $stable(st.live) && o_action == '0;
   endproperty
   a_disabled: assert property (p_disabled) else $error("counted while off");

   property p_once;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && st.fired |=> o_action == '0;
   endproperty
   a_once: assert property (p_once) else $error("action repeated");

   property p_index;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && i_io.wr && i_io.addr == IWDT_PORT_INDEX
      |=> st.index == $past(i_io.wdata);
   endproperty
   a_index: assert property (p_index) else $error("index not taken");

   property p_rvalid;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en |=> o_rvalid == $past(rd_data);
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer wrong");

   property p_relock;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && wr_data && st.index == IWDT_IDX_LOCK && i_io.wdata == IWDT_KEY_LOCK
      |=> !st.unlocked;
   endproperty
   a_relock: assert property (p_relock) else $error("lock key ignored");

   property p_ctrl_write;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && wr_data && st.unlocked && st.index == IWDT_IDX_CTRL
      |=> st.ctrl == $past(i_io.wdata);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl not stored");

   property p_cnt_write;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && wr_data && st.unlocked && st.index == IWDT_IDX_CNT_HI
      |=> st.timeout[23:16] == $past(i_io.wdata)
          && st.timeout[15:0] == $past(st.timeout[15:0]);
   endproperty
   a_cnt_write: assert property (p_cnt_write) else $error("count byte not stored");

   property p_snap;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && wr_data && st.unlocked && st.index == IWDT_IDX_CTRL
      && i_io.wdata[IWDT_CTRL_RDM_BIT] && !st.ctrl[IWDT_CTRL_RDM_BIT]
      |=> st.snap == $past(st.live);
   endproperty
   a_snap: assert property (p_snap) else $error("snapshot not taken");

   property p_snap_read;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && rd_data && st.index == IWDT_IDX_CNT_LO && st.ctrl[IWDT_CTRL_RDM_BIT]
      |=> o_rdata == $past(st.snap[7:0]);
   endproperty
   a_snap_read: assert property (p_snap_read) else $error("snapshot read wrong");

   property p_count_step;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && st.ctrl[IWDT_CTRL_EN_BIT] && !st.fired && !restart && tick
      |=> st.live == $past(st.live) + 24'h1;
   endproperty
   a_count_step: assert property (p_count_step) else $error("tick not counted");

   property p_count_hold;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && st.ctrl[IWDT_CTRL_EN_BIT] && !restart && !tick |=> $stable(st.live);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("count between ticks");

   property p_sysrst;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && hit && !restart && st.act_sel[7:4] == IWDT_ACT_SYSRST
      |=> o_action.sys_rst && !o_action.nmi && o_action.irq == 11'h000;
   endproperty
   a_sysrst: assert property (p_sysrst) else $error("reset action wrong");

   property p_reserved;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && hit && !restart && (st.act_sel[7:4] == 4'h0 || st.act_sel[7:4] >= 4'he)
      |=> o_action == '0 && st.expired;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code acted");

   property p_irq;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_clk_en && hit && !restart && st.act_sel[7:4] == 4'h1
      |=> o_action.irq == 11'h001 && !o_action.nmi && !o_action.sys_rst;
   endproperty
   a_irq: assert property (p_irq) else $error("first line action wrong");

   c_unlock:  cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) st.unlocked);
   c_expire:  cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_action.sys_rst);
   c_snap:    cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
                              $rose(st.ctrl[IWDT_CTRL_RDM_BIT]));
   c_restart: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) restart);
endmodule : iwdt_top
`default_nettype wire

// *** iwdt_host.sv ***
/*
 Host model for the indexed watchdog timer: drives the index/data port pair.
 Assumes the bench calls its tasks at a falling clock edge and that read
 data returns on i_rvalid within a few cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module iwdt_host
(
   input  wire logic                  i_sys_clk,
   input  wire logic [7:0]            i_rdata,
   input  wire logic                  i_rvalid,
   output iwdt_pkg::iwdt_io_type      o_io
);
   import iwdt_pkg::*;
   // ****************************************
   // Port cycles
   // ****************************************
   bit own = 1'b0;
   initial o_io = '0;
   task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
      o_io = '{wr: w, rd: ~w, addr: a, wdata: d};
      @(negedge i_sys_clk);
   endtask : cyc
   // A released bus shows the inverse of its last value, so nothing stale can pass.
   task automatic rel();
      o_io = '{wr: 1'b0, rd: 1'b0, addr: ~o_io.addr, wdata: ~o_io.wdata};
      @(negedge i_sys_clk);
   endtask : rel
   task automatic wr_reg(input logic [7:0] i, input logic [7:0] v);
      cyc(1'b1, IWDT_PORT_INDEX, i);
      cyc(1'b1, IWDT_PORT_DATA, v);
      rel();
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] i, output logic [7:0] v);
      cyc(1'b1, IWDT_PORT_INDEX, i);
      cyc(1'b0, IWDT_PORT_DATA, 8'h00);
      // The strobe drops after one cycle, since a held strobe is a second read.
      o_io = '{wr: 1'b0, rd: 1'b0, addr: ~o_io.addr, wdata: ~o_io.wdata};
      for (int w = 0; w < 4 && i_rvalid !== 1'b1; w++) @(negedge i_sys_clk);
      v = i_rdata;
      @(negedge i_sys_clk);
   endtask : rd_reg
   // Reserved bits are written back as read, never as a guess.
   task automatic rmw(input logic [7:0] i, input logic [7:0] keep, input logic [7:0] set);
      logic [7:0] v;
      own = 1'b1;
      rd_reg(i, v);
      wr_reg(i, (v & keep) | set);
      own = 1'b0;
   endtask : rmw
   task automatic setup(input logic [23:0] n, input logic [3:0] c);
      wr_reg(IWDT_IDX_LOCK, IWDT_KEY_UNLOCK);
      rmw(IWDT_IDX_CTRL, 8'hbf, 8'h00);
      wr_reg(IWDT_IDX_CNT_HI, n[23:16]);
      wr_reg(IWDT_IDX_CNT_MID, n[15:8]);
      wr_reg(IWDT_IDX_CNT_LO, n[7:0]);
      rmw(IWDT_IDX_ACTION, 8'h0f, {c, 4'h0});
      rmw(IWDT_IDX_STATUS, 8'h1f, 8'h20);
      rmw(IWDT_IDX_CTRL, 8'hbf, 8'h40);
   endtask : setup
endmodule : iwdt_host
`default_nettype wire

// *** iwdt_top_tb.sv ***
/*
 Self-checking bench for the indexed watchdog timer.
 Assumes iwdt_pkg, iwdt_top and iwdt_host are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module iwdt_top_tb;
   import iwdt_pkg::*;
   // ****************************************
   // Harness
   // ****************************************
   localparam int    TICK = 2;
   logic             i_sys_clk;
   logic             i_rst_n;
   logic             i_clk_en;
   iwdt_io_type      io;
   logic [7:0]       rdata;
   logic             rvalid;
   iwdt_action_type  act;
   logic [15:0]      rq[$];
   logic [12:0]      aq[$];
   int               n_mismatch = 0;
   int               check_count = 0;
   int               n_act = 0;
   int               k;
   logic [7:0]       v;
   logic [15:0]      mq;
   logic [23:0]      cnt;
   iwdt_top #(.TICK_CYCLES(TICK)) DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en), .i_io(io), .o_rdata(rdata), .o_rvalid(rvalid), .o_action(act));
   iwdt_host host (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_io(io));
   initial
   begin
      i_sys_clk = 1'b0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end
   task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [7:0] m);
      rq.push_back({m, e});
      host.rd_reg(i, v);
   endtask : rd
   function automatic logic [12:0] exp_act(input int c);
      exp_act = '0;
      if (c >= 1 && c <= 11) exp_act[c-1] = 1'b1;
      exp_act[12] = (c == 12);
      exp_act[11] = (c == 13);
   endfunction : exp_act
   // Waits up to 300 cycles for one action pulse; a missing pulse ends the run only when want is set.
   task automatic wait_act(input bit want);
      k = n_act;
      for (int w = 0; w < 300 && n_act == k; w++) @(negedge i_sys_clk);
      if (want && n_act == k)
      begin
         n_mismatch++;
         close_out();
      end
   endtask : wait_act
   // ****************************************
   // Result monitor
   // ****************************************
   always @(negedge i_sys_clk)
   begin
      if (rvalid === 1'b1 && !host.own)
      begin
         if (rq.size() == 0)
            chk(13'h1fff, 13'h0000);
         else
         begin
            mq = rq.pop_front();
            chk({5'h00, rdata & mq[15:8]}, {5'h00, mq[7:0] & mq[15:8]});
         end
      end
      if (act !== '0)
      begin
         n_act++;
         chk(act, aq.size() ? aq.pop_front() : '0);
      end
   end
   initial
   begin
      repeat (100000) @(posedge i_sys_clk);
      n_mismatch++;
      close_out();
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      i_rst_n = 1'b0;
      i_clk_en = 1'b1;
      void'($urandom(32'hc3a9));
      repeat (8) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      @(negedge i_sys_clk);
      rd(IWDT_IDX_CTRL, IWDT_CTRL_RESET, 8'hff);
      rd(IWDT_IDX_CNT_HI, 8'hff, 8'hff);
      rd(IWDT_IDX_STATUS, 8'h00, 8'h80);
      host.wr_reg(IWDT_IDX_CTRL, 8'h40);
      rd(IWDT_IDX_CTRL, 8'h00, 8'hff);
      $display("reset and lock test done");
      host.wr_reg(IWDT_IDX_LOCK, IWDT_KEY_UNLOCK);
      rd(IWDT_IDX_LOCK, 8'h01, 8'h01);
      cnt = {16'h0002, 8'($urandom)};
      host.wr_reg(IWDT_IDX_CNT_HI, 8'h00);
      host.wr_reg(IWDT_IDX_CNT_MID, cnt[15:8]);
      host.wr_reg(IWDT_IDX_CNT_LO, cnt[7:0]);
      host.rmw(IWDT_IDX_STATUS, 8'h1f, 8'h20);
      host.rmw(IWDT_IDX_CTRL, 8'h3f, 8'h80);
      repeat (40) @(negedge i_sys_clk);
      for (int b = 0; b < 3; b++) rd(IWDT_IDX_CNT_LO + 8'(b), 8'h00, 8'hff);
      host.rmw(IWDT_IDX_CTRL, 8'h3f, 8'h00);
      for (int b = 0; b < 3; b++) rd(IWDT_IDX_CNT_LO + 8'(b), cnt[8*b+:8], 8'hff);
      $display("snapshot test done");
      for (int c = 0; c < 16; c++)
      begin
         if (c >= 1 && c <= 13) aq.push_back(exp_act(c));
         host.setup(24'(3 + $urandom % 4), 4'(c));
         wait_act(c >= 1 && c <= 13);
         repeat (40) @(negedge i_sys_clk);
         rd(IWDT_IDX_STATUS, 8'h80, 8'h80);
      end
      $display("action test done");
      host.setup(24'd10, IWDT_ACT_NMI);
      k = n_act;
      repeat (6) host.rmw(IWDT_IDX_STATUS, 8'h1f, 8'h20);
      chk(13'(n_act - k), 13'h0000);
      aq.push_back(exp_act(12));
      wait_act(1'b1);
      host.wr_reg(IWDT_IDX_LOCK, IWDT_KEY_LOCK);
      rd(IWDT_IDX_LOCK, 8'h00, 8'h01);
      host.wr_reg(IWDT_IDX_CTRL, 8'h00);
      rd(IWDT_IDX_CTRL, 8'h40, 8'h40);
      $display("restart and relock test done");
      i_rst_n = 1'b0;
      repeat (3) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      @(negedge i_sys_clk);
      rd(IWDT_IDX_STATUS, 8'h00, 8'h80);
      rd(IWDT_IDX_CTRL, IWDT_CTRL_RESET, 8'hff);
      rd(IWDT_IDX_LOCK, 8'h00, 8'h01);
      $display("mid-run reset test done");
      chk(13'(rq.size() + aq.size()), 13'h0000);
      close_out();
   end
endmodule : iwdt_top_tb
`default_nettype wire
